// *** scpc_pkg.sv ***
// package for the spread clock and multiplying pll control block
// assumes an 8-bit register port with byte offsets on one page
package scpc_pkg;
  localparam logic [7:0] SCPC_ADDR_OPT = 8'h1B;
  localparam logic [7:0] SCPC_ADDR_MUL = 8'h1C;
  localparam logic [7:0] SCPC_ADDR_DIV = 8'h1D;
  localparam logic [7:0] SCPC_ADDR_HLD = 8'h1E;
  localparam logic [7:0] SCPC_RST_OPT = 8'h02;
  localparam logic [7:0] SCPC_RST_MUL = 8'h00;
  localparam logic [7:0] SCPC_RST_DIV = 8'h00;
  localparam logic [7:0] SCPC_RST_HLD = 8'h00;
  localparam int SCPC_B_LOAD = 7;
  localparam int SCPC_B_FIFO_SYNC = 6;
  localparam int SCPC_B_WAVE_SYNC = 5;
  localparam int SCPC_B_OVR2 = 4;
  localparam int SCPC_B_OVR1 = 3;
  localparam int SCPC_B_MAXRATE = 2;
  localparam int SCPC_B_FIFO_RST = 7;
  localparam int SCPC_HLD_W = 7;
  localparam logic [8:0] SCPC_ONE9 = 9'h001;
  localparam logic [6:0] SCPC_ZERO7 = 7'h00;

  typedef enum logic [1:0] {
    SCPC_MODE_OUT_MUL = 2'b00,
    SCPC_MODE_ALL_MUL = 2'b01,
    SCPC_MODE_OFF = 2'b10,
    SCPC_MODE_ALL_NOMUL = 2'b11
  } scpc_mode_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } scpc_wr_s;

  typedef struct packed {
    logic spread_all;
    logic spread_out;
    logic mult_en;
    logic pll_en;
  } scpc_mode_s;
endpackage

// *** scpc_holdoff.sv ***
// delayed one-shot: fires a pulse a programmed number of cycles after a trigger
// assumes the trigger is already synchronised to i_clk
`timescale 1ns/1ps
`default_nettype none
module scpc_holdoff #(
  parameter int W = 7
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_trig,
  input wire logic [W-1:0] i_delay,
  output logic o_fire
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic fire_q;
  wire logic zero_now;
  wire logic done;
  // a zero delay fires one cycle after the trigger; a retrigger restarts the wait
  assign zero_now = i_trig && (i_delay == {W{1'b0}});
  assign done = busy_q && !i_trig && (cnt_q == {{(W-1){1'b0}}, 1'b1});
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      fire_q <= 1'b0;
    end else if (i_ce) begin
      fire_q <= zero_now || done;
      if (i_trig) begin
        cnt_q <= i_delay;
        busy_q <= !zero_now;
      end else if (busy_q) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        busy_q <= !done;
      end
    end
  end
  assign o_fire = fire_q;
endmodule
`default_nettype wire

// *** scpc_top.sv ***
// spread clock modulator and multiplying pll control registers and strobes
// assumes a synchronous byte write/read port and a line sync pulse already
// synchronised to the converter clock
//
// Summary of operation
// (RQ1) option bit 7 loads spreading machine, self-clears
// (RQ2) spreading enable rising also loads machine
// (RQ3) bit 6 adds fifo reset at sync
// (RQ4) software sets bit 6 only in slave mode
// (RQ5) bit 5 restarts spread waveform at sync
// (RQ6) bit 4 forces second pll lock high
// (RQ7) bit 3 forces first pll lock high
// (RQ8) bit 2 forces maximum modulation rate
// (RQ9) pll mode resets to 10, all off
// (RQ10) modes 11, 01, 00 select spread scope
// (RQ11) multiplier is register plus one
// (RQ12) divider is register plus one
// (RQ13) fifo control bit 7 forces fifo reset
// (RQ14) sync resets delayed by 7-bit holdoff
// (RQ15) software disables spreading before changing settings
// (RQ16) command bits pulse once, read back zero
`timescale 1ns/1ps
`default_nettype none
module scpc_top
  import scpc_pkg::*;
#(
  parameter int HLD_W = SCPC_HLD_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire scpc_pkg::scpc_wr_s i_wr,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_spread_en,
  input wire logic i_line_sync_pulse,
  input wire logic i_first_pll_lock,
  input wire logic i_second_pll_lock,
  output logic [7:0] o_rd_data,
  output logic o_sm_load,
  output logic o_fifo_reset,
  output logic o_wave_reset,
  output logic o_first_pll_locked,
  output logic o_second_pll_locked,
  output logic o_max_modulation_rate,
  output scpc_pkg::scpc_mode_s o_mode,
  output logic [8:0] o_mult_m,
  output logic [8:0] o_div_n
);
  import scpc_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [6:0] opt_q;
  logic [7:0] mul_q;
  logic [7:0] div_q;
  logic [6:0] hld_q;
  logic en_q;
  wire logic wr_opt;
  wire logic wr_mul;
  wire logic wr_div;
  wire logic wr_hld;
  wire logic load_cmd;
  wire logic fifo_cmd;
  wire logic en_rise;
  wire logic sync_fire;
  wire logic [7:0] rd_mux;
  wire scpc_mode_s mode_dec;

  // address decode
  assign wr_opt = i_wr.wr && (i_wr.addr == SCPC_ADDR_OPT);
  assign wr_mul = i_wr.wr && (i_wr.addr == SCPC_ADDR_MUL);
  assign wr_div = i_wr.wr && (i_wr.addr == SCPC_ADDR_DIV);
  assign wr_hld = i_wr.wr && (i_wr.addr == SCPC_ADDR_HLD);
  assign load_cmd = wr_opt && i_wr.data[SCPC_B_LOAD]; // RQ1
  assign fifo_cmd = wr_hld && i_wr.data[SCPC_B_FIFO_RST]; // RQ13
  assign en_rise = i_spread_en && !en_q; // RQ2

  // command bits are never stored, so they always read back as zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      opt_q <= SCPC_RST_OPT[6:0]; // RQ9
      mul_q <= SCPC_RST_MUL;
      div_q <= SCPC_RST_DIV;
      hld_q <= SCPC_RST_HLD[6:0];
      en_q <= 1'b0;
    end else if (i_ce) begin
      en_q <= i_spread_en;
      if (wr_opt) opt_q <= i_wr.data[6:0];
      if (wr_mul) mul_q <= i_wr.data;
      if (wr_div) div_q <= i_wr.data;
      if (wr_hld) hld_q <= i_wr.data[6:0];
    end
  end

  // read mux; unmapped offsets read zero
  assign rd_mux = (i_rd_addr == SCPC_ADDR_OPT) ? {1'b0, opt_q} : // RQ16
                  (i_rd_addr == SCPC_ADDR_MUL) ? mul_q :
                  (i_rd_addr == SCPC_ADDR_DIV) ? div_q :
                  (i_rd_addr == SCPC_ADDR_HLD) ? {1'b0, hld_q} : 8'h00;

  // ----------------------------------------------------------------
  // line sync holdoff
  // ----------------------------------------------------------------
  // one shared delay serves both sync resets, as they share one holdoff
  scpc_holdoff #(.W(HLD_W)) u_hold (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_trig(i_line_sync_pulse),
    .i_delay(hld_q[HLD_W-1:0]), // RQ14
    .o_fire(sync_fire)
  );

  // mode decode
  assign mode_dec.spread_all = (opt_q[1:0] == SCPC_MODE_ALL_MUL) ||
                               (opt_q[1:0] == SCPC_MODE_ALL_NOMUL); // RQ10
  assign mode_dec.spread_out = (opt_q[1:0] != SCPC_MODE_OFF);
  assign mode_dec.mult_en = (opt_q[1:0] == SCPC_MODE_ALL_MUL) ||
                            (opt_q[1:0] == SCPC_MODE_OUT_MUL);
  assign mode_dec.pll_en = (opt_q[1:0] != SCPC_MODE_OFF);

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
      o_sm_load <= 1'b0;
      o_fifo_reset <= 1'b0;
      o_wave_reset <= 1'b0;
      o_first_pll_locked <= 1'b0;
      o_second_pll_locked <= 1'b0;
      o_max_modulation_rate <= 1'b0;
      o_mode <= '0;
      o_mult_m <= SCPC_ONE9;
      o_div_n <= SCPC_ONE9;
    end else if (i_ce) begin
      o_rd_data <= rd_mux;
      o_sm_load <= load_cmd || en_rise; // RQ1 RQ2 RQ16
      // spreading start also resets fifo
      o_fifo_reset <= fifo_cmd || load_cmd || en_rise ||
                      (sync_fire && opt_q[SCPC_B_FIFO_SYNC]); // RQ3 RQ13
      o_wave_reset <= sync_fire && opt_q[SCPC_B_WAVE_SYNC]; // RQ5
      o_second_pll_locked <= i_second_pll_lock || opt_q[SCPC_B_OVR2]; // RQ6
      o_first_pll_locked <= i_first_pll_lock || opt_q[SCPC_B_OVR1]; // RQ7
      o_max_modulation_rate <= opt_q[SCPC_B_MAXRATE]; // RQ8
      o_mode <= mode_dec; // RQ10
      o_mult_m <= {1'b0, mul_q} + SCPC_ONE9; // RQ11
      o_div_n <= {1'b0, div_q} + SCPC_ONE9; // RQ12
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_load_pulse: assert property (i_ce && load_cmd |=> o_sm_load) else $error("load missed"); // RQ1
  a_en_rise_load: assert property (i_ce && en_rise |=> o_sm_load) else $error("enable load missed"); // RQ2
  a_fifo_sync: assert property (i_ce && sync_fire && opt_q[SCPC_B_FIFO_SYNC] |=> o_fifo_reset)
    else $error("sync fifo reset missed"); // RQ3
  a_wave_sync: assert property (i_ce |=> o_wave_reset == $past(sync_fire && opt_q[SCPC_B_WAVE_SYNC]))
    else $error("wave reset wrong"); // RQ5
  a_lock2_force: assert property (i_ce && opt_q[SCPC_B_OVR2] |=> o_second_pll_locked)
    else $error("lock2 not forced"); // RQ6
  a_lock1_force: assert property (i_ce && opt_q[SCPC_B_OVR1] |=> o_first_pll_locked)
    else $error("lock1 not forced"); // RQ7
  a_maxrate_out: assert property (i_ce |=> o_max_modulation_rate == $past(opt_q[SCPC_B_MAXRATE]))
    else $error("max rate wrong"); // RQ8
  a_mode_reset: assert property ($fell(i_rst) |-> opt_q[1:0] == SCPC_MODE_OFF)
    else $error("mode reset wrong"); // RQ9
  a_mult_m: assert property (i_ce |=> o_mult_m == {1'b0, $past(mul_q)} + SCPC_ONE9)
    else $error("m wrong"); // RQ11
  a_div_n: assert property (i_ce |=> o_div_n == {1'b0, $past(div_q)} + SCPC_ONE9)
    else $error("n wrong"); // RQ12
  a_fifo_cmd: assert property (i_ce && fifo_cmd |=> o_fifo_reset) else $error("fifo cmd missed"); // RQ13
  a_hold_zero: assert property (i_ce && i_line_sync_pulse && hld_q == SCPC_ZERO7 ##1 i_ce |-> sync_fire)
    else $error("zero holdoff late"); // RQ14
  // a load strobe with no new command behind it must drop after one cycle
  a_load_single: assert property (o_sm_load && i_ce && !load_cmd && !en_rise |=> !o_sm_load)
    else $error("load stuck"); // RQ16

  c_load: cover property (o_sm_load);
  c_sync_fifo: cover property (o_fifo_reset && $past(sync_fire));
  c_wave: cover property (o_wave_reset);
  c_mode_all: cover property (o_mode.spread_all && o_mode.mult_en);
endmodule
`default_nettype wire

// *** test_spread_clock_pll_control.sv ***
// self-checking bench for the spread clock and pll control registers
// assumes scpc_pkg and the design files are compiled first; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_spread_clock_pll_control;
  import scpc_pkg::*;
  logic i_clk, i_rst, i_ce, i_spread_en, i_line_sync_pulse;
  logic i_first_pll_lock, i_second_pll_lock;
  scpc_wr_s i_wr;
  logic [7:0] i_rd_addr, o_rd_data;
  logic o_sm_load, o_fifo_reset, o_wave_reset, o_first_pll_locked, o_second_pll_locked;
  logic o_max_modulation_rate;
  scpc_mode_s o_mode;
  logic [8:0] o_mult_m, o_div_n;
  int mismatches, checks_done, n;

  scpc_top #(.HLD_W(SCPC_HLD_W)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_wr(i_wr),
    .i_rd_addr(i_rd_addr), .i_spread_en(i_spread_en), .i_line_sync_pulse(i_line_sync_pulse),
    .i_first_pll_lock(i_first_pll_lock), .i_second_pll_lock(i_second_pll_lock),
    .o_rd_data(o_rd_data), .o_sm_load(o_sm_load), .o_fifo_reset(o_fifo_reset),
    .o_wave_reset(o_wave_reset), .o_first_pll_locked(o_first_pll_locked),
    .o_second_pll_locked(o_second_pll_locked), .o_max_modulation_rate(o_max_modulation_rate),
    .o_mode(o_mode), .o_mult_m(o_mult_m), .o_div_n(o_div_n));

  // ----------------------------------------
  // access tasks and compare
  // ----------------------------------------
  // inputs always move 1 ns after the rising edge so sampling never races
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one write cycle; callers leave an edge before the next write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr = '{wr: 1'b1, addr: a, data: d};
    step();
    i_wr.wr = 1'b0;
  endtask
  // read data is registered on the same edge that samples the address
  task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
    i_rd_addr = a;
    step();
    chk({1'b0, o_rd_data}, {1'b0, exp});
  endtask
  // pulse the sync line, then count edges until a reset strobe appears
  task automatic sync(input int d, input logic ef, input logic ew);
    i_line_sync_pulse = 1'b1;
    step();
    i_line_sync_pulse = 1'b0;
    n = 0;
    while (!(o_fifo_reset === 1'b1 || o_wave_reset === 1'b1) && n < 200) begin
      step();
      n++;
    end
    if (ef || ew) chk(9'(n), 9'(d + 1));
    chk({8'h00, o_fifo_reset}, {8'h00, ef});
    chk({8'h00, o_wave_reset}, {8'h00, ew});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_wr = '0;
    i_rd_addr = 8'h00;
    i_spread_en = 1'b0;
    i_line_sync_pulse = 1'b0;
    i_first_pll_lock = 1'b0;
    i_second_pll_lock = 1'b0;
    repeat (10) step();
    i_rst = 1'b0;
    chk(o_mult_m, 9'h001);
    chk(o_div_n, 9'h001);
    chk({5'h00, o_mode}, 9'h000);
    rdr(SCPC_ADDR_OPT, 8'h02);
    rdr(SCPC_ADDR_MUL, 8'h00);
    rdr(SCPC_ADDR_DIV, 8'h00);
    rdr(SCPC_ADDR_HLD, 8'h00);
    rdr(8'h1A, 8'h00);
    $display("test reset done");
    // load command pulses once and never reads back
    wr(SCPC_ADDR_OPT, 8'h82);
    chk({7'h00, o_sm_load, o_fifo_reset}, 9'h003);
    step();
    chk({7'h00, o_sm_load, o_fifo_reset}, 9'h000);
    rdr(SCPC_ADDR_OPT, 8'h02);
    i_spread_en = 1'b1;
    step();
    chk({8'h00, o_sm_load}, 9'h001);
    step();
    chk({8'h00, o_sm_load}, 9'h000);
    // settings below change only while spreading is off
    i_spread_en = 1'b0;
    $display("test load done");
    // overrides force lock high with both detectors low
    // outputs follow a stored option one edge after the write lands
    wr(SCPC_ADDR_OPT, 8'h1E);
    step();
    chk({6'h00, o_first_pll_locked, o_second_pll_locked, o_max_modulation_rate}, 9'h007);
    wr(SCPC_ADDR_OPT, 8'h02);
    i_first_pll_lock = 1'b1;
    i_second_pll_lock = 1'b1;
    step();
    chk({6'h00, o_first_pll_locked, o_second_pll_locked, o_max_modulation_rate}, 9'h006);
    for (int c = 0; c < 4; c++) begin
      wr(SCPC_ADDR_OPT, 8'(c));
      step();
      chk({5'h00, o_mode.spread_all, o_mode.spread_out, o_mode.mult_en, o_mode.pll_en},
          {5'h00, c[0], c != 2, !c[1], c != 2});
    end
    $display("test options done");
    // the multiplier covers the full 1 to 256 range; the divider is taken up to 128
    wr(SCPC_ADDR_MUL, 8'hFF);
    step();
    chk(o_mult_m, 9'h100);
    wr(SCPC_ADDR_DIV, 8'h7F);
    step();
    chk(o_div_n, 9'h080);
    rdr(SCPC_ADDR_MUL, 8'hFF);
    rdr(SCPC_ADDR_DIV, 8'h7F);
    // a write with the clock enable low must be lost
    i_ce = 1'b0;
    wr(SCPC_ADDR_MUL, 8'h55);
    i_ce = 1'b1;
    rdr(SCPC_ADDR_MUL, 8'hFF);
    chk(o_mult_m, 9'h100);
    wr(SCPC_ADDR_HLD, 8'h83);
    chk({7'h00, o_fifo_reset, o_sm_load}, 9'h002);
    step();
    chk({8'h00, o_fifo_reset}, 9'h000);
    rdr(SCPC_ADDR_HLD, 8'h03);
    $display("test factors done");
    // holdoff boundaries, then the wave sync option alone, then neither option
    wr(SCPC_ADDR_OPT, 8'h60);
    step();
    wr(SCPC_ADDR_HLD, 8'h7F);
    sync(127, 1'b1, 1'b1);
    wr(SCPC_ADDR_HLD, 8'h03);
    sync(3, 1'b1, 1'b1);
    wr(SCPC_ADDR_HLD, 8'h00);
    sync(0, 1'b1, 1'b1);
    wr(SCPC_ADDR_OPT, 8'h22);
    sync(0, 1'b0, 1'b1);
    wr(SCPC_ADDR_OPT, 8'h02);
    sync(0, 1'b0, 1'b0);
    $display("test sync done");
    // re-enable spreading so the machines reload with the new settings
    i_spread_en = 1'b1;
    step();
    chk({7'h00, o_sm_load, o_fifo_reset}, 9'h003);
    $display("test reload done");
    results();
  end
endmodule
`default_nettype wire
